// ==== rtl/cmpo_defs.svh ====
// register offsets, field positions and reset values for the comparator output block
`ifndef CMPO_DEFS_SVH
`define CMPO_DEFS_SVH
// register indices as printed; byte address is four times the index
`define CMPO_IDX_CTRL0_C1 10'h119
`define CMPO_IDX_CTRL0_C2 10'h11a
`define CMPO_IDX_CTRL1 10'h11b
`define CMPO_IDX_FLAG 10'h00d
`define CMPO_IDX_IEN 10'h08d
`define CMPO_IDX_IRQCTL 10'h00b
`define CMPO_IDX_LATCH 10'h19e
// control0 fields
`define CMPO_C0_ON 7
`define CMPO_C0_OUT 6
`define CMPO_C0_OE 5
`define CMPO_C0_POL 4
`define CMPO_C0_WMASK 8'hb7
// control1 fields
`define CMPO_C1_M1 7
`define CMPO_C1_M2 6
`define CMPO_C1_GSS 1
`define CMPO_C1_SYNC 0
`define CMPO_C1_RESET 2'h2
// flag and enable fields
`define CMPO_FL_C2 6
`define CMPO_FL_C1 5
`define CMPO_IC_GIE 7
`define CMPO_IC_PERIPH_IRQ_EN 6
// latch control fields
`define CMPO_LC_CFG_HI 7
`define CMPO_LC_CFG_LO 6
`define CMPO_LC_SEN 5
`define CMPO_LC_REN 4
`define CMPO_LC_PSET 3
`define CMPO_LC_PRST 2
`define CMPO_LC_WMASK 8'hf0
`endif

// ==== rtl/cmpo_pkg.sv ====
// types shared by the comparator output block
package cmpo_pkg;
    // per-comparator control state
    typedef struct packed {
        logic on;
        logic oe;
        logic pol;
        logic [2:0] misc;
    } cmpo_ctrl_s;
    // latch control state
    typedef struct packed {
        logic [1:0] cfg;
        logic set_en;
        logic rst_en;
    } cmpo_latch_s;
endpackage

// ==== rtl/cmpo_sync2.sv ====
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module cmpo_sync2 (
    input wire logic i_core_clk, // core clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic i_d, // asynchronous level
    output logic o_q // synchronised level
);
    logic meta_q; // first stage, read only by the second
    // ****************************************
    // two stage capture
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_q <= 1'b0;
            o_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/cmpo_change_det.sv ====
// one comparator's mismatch latch and change event
`timescale 1ns/1ps
`default_nettype none
module cmpo_change_det (
    input wire logic i_core_clk, // core clock
    input wire logic i_rst_b, // synchronised reset, active low
    input wire logic i_out, // polarity-corrected output
    input wire logic i_refresh, // control0 access refreshes latch
    output logic o_change // one-cycle change event
);
    logic mism_q; // mismatch latch: last value seen
    logic diff_q; // mismatch level, delayed one cycle
    wire diff = i_out ^ mism_q; // live mismatch level
    // ****************************************
    // latch and edge detection
    // ****************************************
    // the event is the edge of the mismatch, so a standing mismatch flags once
    assign o_change = diff & ~diff_q;
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            mism_q <= 1'b0;
            diff_q <= 1'b0;
        end
        else
        begin
            // latch updates only on control0 access, never otherwise
            if (i_refresh)
                mism_q <= i_out;
            diff_q <= diff & ~i_refresh;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/cmpo_top.sv ====
// comparator digital output path with apb register file
// Notes on behaviour
// - sync bit: comparator 2 caught on falling edge
// - with prescaler, capture clock is prescaler output
// - timer rises, capture falls, avoiding races
// - control1 bits 7:6 mirror both outputs
// - mirror reads leave mismatch latches alone
// - gate select resets 1; 1 pin, 0 comparator
// - pins carry unsynchronised output, direction enables
// - polarity bit 4 inverts comparator output
// - output change sets flag bits 6 and 5
// - flags cleared by writing 0, 1 sets
// - request needs three enables; flags set regardless
// - flag set by mismatch edge, not level
// - refreshed latch flags return to old value
// - change during control read may be lost; here the change still sets its flag
// - every reset disables the latch
// - two-bit config picks routing, independent enable
// - reset-dominant latch, set from synced comparator 1 output, reset from synced comparator 2 output
// - set pulse bit pulses latch set
// - reset pulse bit pulses latch reset
`timescale 1ns/1ps
`default_nettype none
`include "cmpo_defs.svh"
module cmpo_top
    import cmpo_pkg::*;
(
    input wire logic i_core_clk, // core clock, 100 MHz
    input wire logic i_rst_b, // async reset, active low
    input wire logic [11:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic i_cmp1_raw, // analog comparator 1 result
    input wire logic i_cmp2_raw, // analog comparator 2 result
    input wire logic i_tmr_clk, // timer clock after prescaler
    input wire logic i_timer_gate_pin, // external gate pin
    input wire logic [1:0] i_pin_direction, // port direction, 0 = output
    output logic o_timer_gate, // gate to the timer
    output logic [1:0] o_pin_out, // comparator pin levels
    output logic [1:0] o_pin_oe, // comparator pin drive enables
    output logic o_irq // comparator interrupt request
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_q; // first release stage
    logic rst_sync_b_q; // released reset for the design
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_b_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_b_q <= rst_meta_q;
        end
    end

    // ****************************************
    // register state
    // ****************************************
    cmpo_ctrl_s c1_q; // comparator 1 control0
    cmpo_ctrl_s c2_q; // comparator 2 control0
    logic gss_q; // timer gate source select
    logic sync_q; // comparator 2 sync select
    logic [1:0] flag_q; // interrupt flags, [1]=cmp2 [0]=cmp1
    logic [1:0] ien_q; // comparator interrupt enables
    logic periph_irq_en_q; // peripheral enable
    logic gie_q; // global enable
    cmpo_latch_s lc_q; // latch control
    logic [7:0] rdata_q; // registered read data

    // ****************************************
    // comparator output path
    // ****************************************
    // polarity acts before status, latch and pins
    wire c1_async = (i_cmp1_raw ^ c1_q.pol) & c1_q.on;
    wire c2_async = (i_cmp2_raw ^ c2_q.pol) & c2_q.on;
    // capture on falling timer edge while the timer counts on rising,
    // so the gate is stable at every increment; the timer clock input
    // is already the prescaler output
    logic c2_fall_q; // comparator 2 caught on falling edge
    always_ff @(negedge i_tmr_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            c2_fall_q <= 1'b0;
        else
            c2_fall_q <= c2_async;
    end
    wire c2_eff = sync_q ? c2_fall_q : c2_async;
    // gate mux is analog-side, no core clock in the path
    assign o_timer_gate = gss_q ? i_timer_gate_pin : c2_eff;

    // status values synchronised into the core domain
    logic c1_s; // synced comparator 1
    logic c2_s; // synced comparator 2
    cmpo_sync2 u_sync_c1 (
        .i_core_clk(i_core_clk),
        .i_rst_b(rst_sync_b_q),
        .i_d(c1_async),
        .o_q(c1_s)
    );
    cmpo_sync2 u_sync_c2 (
        .i_core_clk(i_core_clk),
        .i_rst_b(rst_sync_b_q),
        .i_d(c2_eff),
        .o_q(c2_s)
    );

    // ****************************************
    // apb decode
    // ****************************************
    wire [9:0] idx = paddr[11:2]; // word index
    wire acc = psel & penable; // access phase, always ready
    wire wr = acc & pwrite & pstrb[0];
    // read data is captured in the setup cycle, so it already stands
    // at the rising edge where the master samples pready high
    wire rd = psel & ~penable & ~pwrite;
    wire hit_c1 = idx == `CMPO_IDX_CTRL0_C1;
    wire hit_c2 = idx == `CMPO_IDX_CTRL0_C2;
    wire hit_ct1 = idx == `CMPO_IDX_CTRL1;
    wire hit_fl = idx == `CMPO_IDX_FLAG;
    wire hit_ie = idx == `CMPO_IDX_IEN;
    wire hit_ic = idx == `CMPO_IDX_IRQCTL;
    wire hit_lc = idx == `CMPO_IDX_LATCH;
    wire hit_any = hit_c1 | hit_c2 | hit_ct1 | hit_fl | hit_ie | hit_ic | hit_lc;
    wire [7:0] wd = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = acc & ~hit_any; // unmapped address
    assign prdata = {24'h000000, rdata_q};

    // ****************************************
    // change detection
    // ****************************************
    // only control0 accesses refresh, control1 mirror reads do not
    wire ref1 = acc & hit_c1;
    wire ref2 = acc & hit_c2;
    logic [1:0] chg; // change events
    // a change coinciding with the refreshing read still raises a flag,
    // as the event uses the latch value from before the refresh
    cmpo_change_det u_det_c1 (
        .i_core_clk(i_core_clk),
        .i_rst_b(rst_sync_b_q),
        .i_out(c1_s),
        .i_refresh(ref1),
        .o_change(chg[0])
    );
    cmpo_change_det u_det_c2 (
        .i_core_clk(i_core_clk),
        .i_rst_b(rst_sync_b_q),
        .i_out(c2_s),
        .i_refresh(ref2),
        .o_change(chg[1])
    );

    // ****************************************
    // flags and interrupt request
    // ****************************************
    // write replaces, hardware event wins over a clearing write
    wire [1:0] flag_w = {wd[`CMPO_FL_C2], wd[`CMPO_FL_C1]};
    wire [1:0] flag_d = ((wr & hit_fl) ? flag_w : flag_q) | chg;
    assign o_irq = |(flag_q & ien_q) & periph_irq_en_q & gie_q;

    // ****************************************
    // sr latch
    // ****************************************
    // latch state is kept as a register for clean timing; pulse bits
    // act for one cycle on the write
    wire pset = wr & hit_lc & wd[`CMPO_LC_PSET];
    wire prst = wr & hit_lc & wd[`CMPO_LC_PRST];
    wire s_in = (c1_s & lc_q.set_en) | pset;
    wire r_in = (c2_s & lc_q.rst_en) | prst;
    logic sr_q; // latch output
    wire sr_d = r_in ? 1'b0 : (s_in ? 1'b1 : sr_q);

    // ****************************************
    // pin routing
    // ****************************************
    // config low bit routes latch q to pin 1, high bit routes ~q to pin 2
    wire pin1_lat = lc_q.cfg[0];
    wire pin2_lat = lc_q.cfg[1];
    logic [1:0] pin_q; // registered pin data
    wire [1:0] pin_d = {pin2_lat ? ~sr_q : c2_async,
                        pin1_lat ? sr_q : c1_async};
    // direction bit still gates the driver
    assign o_pin_oe = {c2_q.oe & c2_q.on & ~i_pin_direction[1],
                       c1_q.oe & c1_q.on & ~i_pin_direction[0]};
    assign o_pin_out = pin_q;

    // ****************************************
    // read mux
    // ****************************************
    logic [7:0] rmux; // selected read value
    always_comb
    begin
        rmux = 8'h00;
        if (hit_c1)
            rmux = {c1_q.on, c1_s, c1_q.oe, c1_q.pol, 1'b0, c1_q.misc};
        else if (hit_c2)
            rmux = {c2_q.on, c2_s, c2_q.oe, c2_q.pol, 1'b0, c2_q.misc};
        else if (hit_ct1)
            rmux = {c1_s, c2_s, 4'h0, gss_q, sync_q};
        else if (hit_fl)
            rmux = {1'b0, flag_q, 5'h00};
        else if (hit_ie)
            rmux = {1'b0, ien_q, 5'h00};
        else if (hit_ic)
            rmux = {gie_q, periph_irq_en_q, 6'h00};
        else if (hit_lc)
            rmux = {lc_q, 4'h0}; // pulse bits read zero
    end

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge i_core_clk or negedge rst_sync_b_q)
    begin
        if (!rst_sync_b_q)
        begin
            c1_q <= '0;
            c2_q <= '0;
            {gss_q, sync_q} <= `CMPO_C1_RESET;
            flag_q <= 2'h0;
            ien_q <= 2'h0;
            periph_irq_en_q <= 1'b0;
            gie_q <= 1'b0;
            lc_q <= '0;
            sr_q <= 1'b0;
            pin_q <= 2'h0;
            rdata_q <= 8'h00;
        end
        else
        begin
            flag_q <= flag_d;
            sr_q <= sr_d;
            pin_q <= pin_d;
            if (rd)
                rdata_q <= rmux;
            if (wr & hit_c1)
                c1_q <= {wd[`CMPO_C0_ON], wd[`CMPO_C0_OE], wd[`CMPO_C0_POL], wd[2:0]};
            if (wr & hit_c2)
                c2_q <= {wd[`CMPO_C0_ON], wd[`CMPO_C0_OE], wd[`CMPO_C0_POL], wd[2:0]};
            if (wr & hit_ct1)
                {gss_q, sync_q} <= {wd[`CMPO_C1_GSS], wd[`CMPO_C1_SYNC]};
            if (wr & hit_ie)
                ien_q <= {wd[`CMPO_FL_C2], wd[`CMPO_FL_C1]};
            if (wr & hit_ic)
                {gie_q, periph_irq_en_q} <= {wd[`CMPO_IC_GIE], wd[`CMPO_IC_PERIPH_IRQ_EN]};
            if (wr & hit_lc)
                lc_q <= {wd[`CMPO_LC_CFG_HI], wd[`CMPO_LC_CFG_LO],
                         wd[`CMPO_LC_SEN], wd[`CMPO_LC_REN]};
        end
    end
endmodule
`default_nettype wire

// ==== dv/cmpo_top_monitor.sv ====
// port-level assertions for the comparator output block
`timescale 1ns/1ps
`default_nettype none
`include "cmpo_defs.svh"
module cmpo_top_monitor (
    input wire logic i_core_clk, // core clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb strobes
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic i_cmp2_raw, // comparator 2 result
    input wire logic i_timer_gate_pin, // gate pin
    input wire logic [1:0] i_pin_direction, // port direction
    input wire logic o_timer_gate, // timer gate
    input wire logic [1:0] o_pin_oe, // pin enables
    input wire logic o_irq // interrupt request
);
    // ****************************************
    // shadow of software-written fields
    // ****************************************
    logic acc; // access phase
    logic wr; // write takes effect
    logic [9:0] idx; // register index
    logic mapped; // index names a register
    logic [7:0] c1_q; // comparator 1 control0
    logic [7:0] c2_q; // comparator 2 control0
    logic [1:0] k1_q; // gate select, sync
    logic [7:0] ie_q; // interrupt enables
    logic [7:0] ic_q; // global enables
    assign acc = psel & penable;
    assign wr = acc & pwrite & pstrb[0];
    assign idx = paddr[11:2];
    assign mapped = idx inside {`CMPO_IDX_CTRL0_C1, `CMPO_IDX_CTRL0_C2, `CMPO_IDX_CTRL1,
        `CMPO_IDX_FLAG, `CMPO_IDX_IEN, `CMPO_IDX_IRQCTL, `CMPO_IDX_LATCH};
    // only written bits are kept; hardware-set flags cannot be shadowed
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            c1_q <= 8'h00;
            c2_q <= 8'h00;
            k1_q <= `CMPO_C1_RESET;
            ie_q <= 8'h00;
            ic_q <= 8'h00;
        end
        else if (wr)
        begin
            if (idx == `CMPO_IDX_CTRL0_C1)
                c1_q <= pwdata[7:0];
            if (idx == `CMPO_IDX_CTRL0_C2)
                c2_q <= pwdata[7:0];
            if (idx == `CMPO_IDX_CTRL1)
                k1_q <= pwdata[1:0];
            if (idx == `CMPO_IDX_IEN)
                ie_q <= pwdata[7:0];
            if (idx == `CMPO_IDX_IRQCTL)
                ic_q <= pwdata[7:0];
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    a_zero_wait: assert property (acc |-> pready)
        else $error("access phase without ready");
    a_unmapped_err: assert property (acc && paddr[1:0] == 2'b00 |-> pslverr == !mapped)
        else $error("error response does not match decode");
    a_ctrl1_fields: assert property (acc && !pwrite && idx == `CMPO_IDX_CTRL1
        |-> prdata[31:8] == 24'h000000 && prdata[5:0] == {4'h0, k1_q})
        else $error("control1 readback wrong");
    a_pulse_zero: assert property (acc && !pwrite && idx == `CMPO_IDX_LATCH
        |-> prdata[3:0] == 4'h0)
        else $error("latch pulse bits read nonzero");
    a_pin_oe: assert property (o_pin_oe ==
        {c2_q[7] & c2_q[5] & ~i_pin_direction[1], c1_q[7] & c1_q[5] & ~i_pin_direction[0]})
        else $error("pin enable wrong");
    a_irq_gated: assert property (o_irq |-> ic_q[7] && ic_q[6] && ie_q[6:5] != 2'b00)
        else $error("request without all enables");
    a_gate_pin: assert property (k1_q[1] |-> o_timer_gate == i_timer_gate_pin)
        else $error("gate not following pin");
    a_gate_async: assert property (
        (!k1_q[1] && !k1_q[0] && $stable(i_cmp2_raw) && $stable(c2_q)) [*3]
        |-> o_timer_gate == (c2_q[7] & (i_cmp2_raw ^ c2_q[4])))
        else $error("async gate wrong");
endmodule
bind cmpo_top cmpo_top_monitor i_mon (.i_core_clk, .i_rst_b, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .i_cmp2_raw, .i_timer_gate_pin,
    .i_pin_direction, .o_timer_gate, .o_pin_oe, .o_irq);
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking testbench for the comparator output block
`timescale 1ns/1ps
`default_nettype none
`include "cmpo_defs.svh"
module tb;
    logic i_core_clk, i_rst_b, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic i_cmp1_raw, i_cmp2_raw, i_tmr_clk, i_timer_gate_pin, o_timer_gate, o_irq;
    logic [1:0] i_pin_direction, o_pin_out, o_pin_oe;
    logic [7:0] r; // last read byte
    logic [7:0] fb; // flag bit of comparator
    logic [9:0] ix; // control0 index
    logic [3:0] p; // random pol and raw
    int failures, checks;
    cmpo_top i_dut (.i_core_clk, .i_rst_b, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .i_cmp1_raw, .i_cmp2_raw, .i_tmr_clk,
        .i_timer_gate_pin, .i_pin_direction, .o_timer_gate, .o_pin_out, .o_pin_oe, .o_irq);
    initial
    begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // one apb transfer; bounded wait on ready
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge i_core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            e = pslverr;
            r = prdata[7:0];
            n++;
            if (n > 50)
            begin
                failures++;
                tally_and_finish;
            end
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] x, m);
        apb(1'b0, a, 8'h00);
        chk(nm, r & m, x);
    endtask
    task automatic setraw(input int i, input logic v);
        @(posedge i_core_clk);
        if (i == 0)
            i_cmp1_raw <= v;
        else
            i_cmp2_raw <= v;
    endtask
    // pins with comparator 1 high, comparator 2 low
    function automatic logic [7:0] pins_exp(input logic [1:0] cfg, input logic q);
        return {6'h0, cfg[1] ? !q : 1'b0, cfg[0] ? q : 1'b1};
    endfunction
    initial
    begin
        {psel, penable, pwrite, i_cmp1_raw, i_cmp2_raw, i_tmr_clk, i_timer_gate_pin} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        i_pin_direction = 2'b00;
        failures = 0;
        checks = 0;
        void'($urandom(62098));
        i_rst_b = 1'b0;
        cyc(2);
        i_rst_b <= 1'b1;
        cyc(3);
        rd("ctrl1", `CMPO_IDX_CTRL1, 8'h02, 8'hff);
        rd("latch", `CMPO_IDX_LATCH, 8'h00, 8'hff);
        apb(1'b0, 10'h3f0, 8'h00);
        chk("slverr", {7'h0, e}, 8'h01);
        $display("test reset done");
        for (int k = 0; k < 8; k++)
        begin
            p = (k == 0) ? 4'hf : 4'($urandom);
            apb(1'b1, `CMPO_IDX_CTRL0_C1, {3'b100, p[0], 4'h0});
            apb(1'b1, `CMPO_IDX_CTRL0_C2, {3'b100, p[1], 4'h0});
            setraw(0, p[2]);
            setraw(1, p[3]);
            cyc(4);
            rd("mirror", `CMPO_IDX_CTRL1, {p[2] ^ p[0], p[3] ^ p[1], 6'h0}, 8'hc0);
            rd("out1", `CMPO_IDX_CTRL0_C1, {1'b1, p[2] ^ p[0], 1'b0, p[0], 4'h0}, 8'hd0);
        end
        $display("test polarity done");
        for (int i = 0; i < 2; i++)
        begin
            ix = (i == 0) ? `CMPO_IDX_CTRL0_C1 : `CMPO_IDX_CTRL0_C2;
            fb = (i == 0) ? 8'h20 : 8'h40;
            apb(1'b1, ix, 8'h80);
            setraw(i, 1'b0);
            cyc(4);
            apb(1'b0, ix, 8'h00);
            apb(1'b1, `CMPO_IDX_FLAG, 8'h00);
            setraw(i, 1'b1);
            cyc(4);
            rd("flag set", `CMPO_IDX_FLAG, fb, 8'h60);
            apb(1'b1, `CMPO_IDX_FLAG, 8'h00);
            cyc(4);
            rd("flag clear", `CMPO_IDX_FLAG, 8'h00, 8'h60);
            apb(1'b0, `CMPO_IDX_CTRL1, 8'h00);
            setraw(i, 1'b0);
            cyc(4);
            rd("no return flag", `CMPO_IDX_FLAG, 8'h00, 8'h60);
            setraw(i, 1'b1);
            cyc(4);
            apb(1'b1, `CMPO_IDX_FLAG, 8'h00);
            apb(1'b0, ix, 8'h00);
            setraw(i, 1'b0);
            cyc(4);
            rd("return flag", `CMPO_IDX_FLAG, fb, 8'h60);
        end
        $display("test flags done");
        apb(1'b1, `CMPO_IDX_FLAG, 8'h60);
        rd("soft set", `CMPO_IDX_FLAG, 8'h60, 8'h60);
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, `CMPO_IDX_IEN, {1'b0, k[2], 6'h0});
            apb(1'b1, `CMPO_IDX_IRQCTL, {k[1], k[0], 6'h0});
            cyc(1);
            chk("irq", {7'h0, o_irq}, {7'h0, &k[2:0]});
        end
        apb(1'b1, `CMPO_IDX_FLAG, 8'h00);
        cyc(1);
        chk("irq off", {7'h0, o_irq}, 8'h00);
        $display("test irq done");
        apb(1'b1, `CMPO_IDX_CTRL0_C2, 8'h80);
        apb(1'b1, `CMPO_IDX_CTRL1, 8'h00);
        setraw(1, 1'b1);
        cyc(4);
        chk("gate async", {7'h0, o_timer_gate}, 8'h01);
        apb(1'b1, `CMPO_IDX_CTRL1, 8'h01);
        i_tmr_clk <= 1'b1;
        cyc(4);
        i_tmr_clk <= 1'b0;
        setraw(1, 1'b0);
        cyc(4);
        chk("gate held", {7'h0, o_timer_gate}, 8'h01);
        i_tmr_clk <= 1'b1;
        cyc(4);
        chk("no rise capture", {7'h0, o_timer_gate}, 8'h01);
        i_tmr_clk <= 1'b0;
        cyc(4);
        chk("fall capture", {7'h0, o_timer_gate}, 8'h00);
        apb(1'b1, `CMPO_IDX_CTRL1, 8'h02);
        for (int k = 0; k < 4; k++)
        begin
            i_timer_gate_pin <= k[0];
            cyc(2);
            chk("gate pin", {7'h0, o_timer_gate}, {7'h0, k[0]});
        end
        $display("test gate done");
        apb(1'b1, `CMPO_IDX_CTRL0_C1, 8'ha0);
        apb(1'b1, `CMPO_IDX_CTRL0_C2, 8'ha0);
        setraw(0, 1'b1);
        for (int k = 3; k >= 0; k--)
        begin
            i_pin_direction <= 2'(k);
            cyc(1);
            chk("pin oe", {6'h0, o_pin_oe}, {6'h0, ~2'(k)});
        end
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, `CMPO_IDX_LATCH, {4'hc, k[2], !k[2], 2'b00});
            apb(1'b1, `CMPO_IDX_LATCH, {k[1:0], 6'h00});
            cyc(4);
            chk("pins", {6'h0, o_pin_out}, pins_exp(2'(k), k[2]));
        end
        apb(1'b1, `CMPO_IDX_LATCH, 8'hcc);
        cyc(4);
        chk("pulse reset wins", {6'h0, o_pin_out}, pins_exp(2'b11, 1'b0));
        apb(1'b1, `CMPO_IDX_LATCH, 8'he0);
        cyc(4);
        chk("cmp set", {6'h0, o_pin_out}, pins_exp(2'b11, 1'b1));
        setraw(1, 1'b1);
        apb(1'b1, `CMPO_IDX_LATCH, 8'hf0);
        cyc(4);
        chk("cmp reset wins", {6'h0, o_pin_out}, pins_exp(2'b11, 1'b0));
        rd("pulse bits", `CMPO_IDX_LATCH, 8'hf0, 8'hff);
        $display("test latch done");
        i_rst_b <= 1'b0;
        cyc(2);
        i_rst_b <= 1'b1;
        cyc(3);
        rd("latch off", `CMPO_IDX_LATCH, 8'h00, 8'hff);
        rd("ctrl1 again", `CMPO_IDX_CTRL1, 8'h02, 8'h3f);
        $display("test second reset done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
